//--- rtl/isr_defs.svh
// Register offsets, field widths and reset values of the status reporting block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef ISR_DEFS_SVH
`define ISR_DEFS_SVH
`define ISR_QUES_COND 8'h00
`define ISR_QUES_PTR 8'h04
`define ISR_QUES_NTR 8'h08
`define ISR_QUES_EVENT 8'h0C
`define ISR_QUES_ENABLE 8'h10
`define ISR_OPER_COND 8'h14
`define ISR_OPER_PTR 8'h18
`define ISR_OPER_NTR 8'h1C
`define ISR_OPER_EVENT 8'h20
`define ISR_OPER_ENABLE 8'h24
`define ISR_ESR_EVENT 8'h28
`define ISR_ESR_ENABLE 8'h2C
`define ISR_STB_EVENT 8'h30
`define ISR_STB_ENABLE 8'h34
`define ISR_IRQ_STATUS 8'h38
`define ISR_IRQ_MASK 8'h3C
`define ISR_WIDE 16
`define ISR_NARROW 8
`define ISR_PTR_RESET 16'hFFFF
`define ISR_RESP_OKAY 2'b00
`define ISR_RESP_SLVERR 2'b10
`endif

//--- rtl/isr_pkg.sv
// Types shared by the status reporting block.
// Assumes isr_defs.svh is reachable on the include path.
`default_nettype none
package isr_pkg;
   typedef enum logic [1:0] {
      ISR_IDLE = 2'b00,
      ISR_RESP = 2'b01
   } isr_bus_state_t;
endpackage
`default_nettype wire

//--- rtl/isr_reg_set.sv
// One status register set: transition filter, clear-on-read event latch, enable gate.
// Assumes conditions are already synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module isr_reg_set #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] PTR_RESET = '1
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Live condition and filters.
   input wire logic [WIDTH-1:0] cond,
   input wire logic [WIDTH-1:0] ptr,
   input wire logic [WIDTH-1:0] ntr,
   input wire logic [WIDTH-1:0] enable,
   // Event read clear.
   input wire logic read_clear,
   // Results.
   output logic [WIDTH-1:0] event_bits,
   output logic summary,
   output logic new_event
);
   typedef struct packed {
      logic [WIDTH-1:0] last;
      logic [WIDTH-1:0] ev;
   } isr_set_state_t;
   isr_set_state_t st;
   isr_set_state_t next_st;
   logic [WIDTH-1:0] hit;
   always_comb begin
      hit = (cond & ~st.last & ptr) | (~cond & st.last & ntr); // RQ5
      next_st.last = cond;
      // A capture in the reading cycle survives the clear so no event is lost.
      next_st.ev = (read_clear ? '0 : st.ev) | hit; // RQ6
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign event_bits = st.ev;
   assign summary = |(st.ev & enable); // RQ7 RQ8
   assign new_event = |hit;
endmodule
`default_nettype wire

//--- rtl/isr_status_top.sv
// Status reporting block: four register sets behind an AXI4-Lite slave.
// Assumes instrument and standard status inputs arrive from pins and are resynchronised here.
// Contract
// RQ1: Questionable and Operation sets are sixteen bits, inputs defined by the instrument.
// RQ2: Event Status and Status Byte sets are eight bits with standard inputs.
// RQ3: All sets have event and enable; wide sets add condition and transition.
// RQ4: Wide condition registers mirror live status unlatched, readable any time.
// RQ5: Condition changes latch into events only when transition filter selects them.
// RQ6: Reading an event register returns its bits and clears them.
// RQ7: An event bit is reported only while its enable bit is one; irq_status sets on any new event in a set regardless of enable.
// RQ8: Each set drives a summary: OR of event AND enable, every cycle.
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"
module isr_status_top (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Status inputs from the instrument.
   input wire logic [15:0] ques_in,
   input wire logic [15:0] oper_in,
   input wire logic [7:0] esr_in,
   input wire logic [7:0] stb_in,
   // AXI4-Lite write address.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Summaries and interrupt.
   output logic ques_summary,
   output logic oper_summary,
   output logic esr_summary,
   output logic stb_summary,
   output logic irq
);
   localparam int W = `ISR_WIDE;
   localparam int N = `ISR_NARROW;
   typedef struct packed {
      logic [W+N-1:0] q1;
      logic [W+N-1:0] q2;
      logic [W+N-1:0] q3;
      logic [W+N-1:0] qhold;
      logic [W+N-1:0] o1;
      logic [W+N-1:0] o2;
      logic [W+N-1:0] o3;
      logic [W+N-1:0] ohold;
      logic [W-1:0] ques_ptr;
      logic [W-1:0] ques_ntr;
      logic [W-1:0] ques_en;
      logic [W-1:0] oper_ptr;
      logic [W-1:0] oper_ntr;
      logic [W-1:0] oper_en;
      logic [N-1:0] esr_en;
      logic [N-1:0] stb_en;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      isr_pkg::isr_bus_state_t wr_state;
      logic [1:0] bresp;
      isr_pkg::isr_bus_state_t rd_state;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } isr_top_state_t;
   isr_top_state_t st;
   isr_top_state_t next_st;
   // Three-stage synchronisers: only stage two reads stage one; stages two and three must agree.
   logic [W+N-1:0] s0;
   logic [W+N-1:0] o0;
   logic [W-1:0] ques_cond;
   logic [W-1:0] oper_cond;
   logic [N-1:0] esr_cond;
   logic [N-1:0] stb_cond;
   logic [W+N-1:0] agreed;
   logic [W+N-1:0] held;
   logic [W+N-1:0] oagreed;
   logic [W+N-1:0] oheld;
   logic [W-1:0] ques_ev;
   logic [W-1:0] oper_ev;
   logic [N-1:0] esr_ev;
   logic [N-1:0] stb_ev;
   logic [3:0] set_new;
   logic [3:0] rd_clr;
   logic rd_go;
   logic wr_go;
   assign s0 = {ques_in, esr_in};
   assign o0 = {oper_in, stb_in};
   assign agreed = ~(st.q2 ^ st.q3);
   assign oagreed = ~(st.o2 ^ st.o3);
   // A half-settled change is held off until two stages agree, trading one cycle of delay for glitch immunity.
   assign held = (agreed & st.q3) | (~agreed & st.qhold);
   assign oheld = (oagreed & st.o3) | (~oagreed & st.ohold);
   assign ques_cond = held[W+N-1:N]; // RQ4
   assign esr_cond = held[N-1:0];
   assign oper_cond = oheld[W+N-1:N]; // RQ4
   assign stb_cond = oheld[N-1:0];
   assign rd_go = s_axi_arvalid && st.rd_state == isr_pkg::ISR_IDLE;
   always_comb begin
      rd_clr = 4'h0;
      if (rd_go) begin
         if (s_axi_araddr == `ISR_QUES_EVENT) begin
            rd_clr[0] = 1'b1; // RQ6
         end else if (s_axi_araddr == `ISR_OPER_EVENT) begin
            rd_clr[1] = 1'b1; // RQ6
         end else if (s_axi_araddr == `ISR_ESR_EVENT) begin
            rd_clr[2] = 1'b1; // RQ6
         end else if (s_axi_araddr == `ISR_STB_EVENT) begin
            rd_clr[3] = 1'b1; // RQ6
         end
      end
   end
   isr_reg_set #(.WIDTH(W), .PTR_RESET(`ISR_PTR_RESET)) u_ques ( // RQ1 RQ3
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(ques_cond),
      .ptr(st.ques_ptr),
      .ntr(st.ques_ntr),
      .enable(st.ques_en),
      .read_clear(rd_clr[0]),
      .event_bits(ques_ev),
      .summary(ques_summary),
      .new_event(set_new[0])
   );
   isr_reg_set #(.WIDTH(W), .PTR_RESET(`ISR_PTR_RESET)) u_oper ( // RQ1 RQ3
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(oper_cond),
      .ptr(st.oper_ptr),
      .ntr(st.oper_ntr),
      .enable(st.oper_en),
      .read_clear(rd_clr[1]),
      .event_bits(oper_ev),
      .summary(oper_summary),
      .new_event(set_new[1])
   );
   // Standard sets latch rising edges of their inputs; no filter is exposed for them.
   isr_reg_set #(.WIDTH(N), .PTR_RESET(8'hFF)) u_esr ( // RQ2 RQ3
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(esr_cond),
      .ptr(8'hFF),
      .ntr(8'h00),
      .enable(st.esr_en),
      .read_clear(rd_clr[2]),
      .event_bits(esr_ev),
      .summary(esr_summary),
      .new_event(set_new[2])
   );
   isr_reg_set #(.WIDTH(N), .PTR_RESET(8'hFF)) u_stb ( // RQ2 RQ3
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(stb_cond),
      .ptr(8'hFF),
      .ntr(8'h00),
      .enable(st.stb_en),
      .read_clear(rd_clr[3]),
      .event_bits(stb_ev),
      .summary(stb_summary),
      .new_event(set_new[3])
   );
   assign wr_go = (st.aw_held || s_axi_awvalid) && (st.w_held || s_axi_wvalid) &&
      st.wr_state == isr_pkg::ISR_IDLE;
   assign s_axi_awready = !st.aw_held && st.wr_state == isr_pkg::ISR_IDLE;
   assign s_axi_wready = !st.w_held && st.wr_state == isr_pkg::ISR_IDLE;
   assign s_axi_arready = st.rd_state == isr_pkg::ISR_IDLE;
   assign s_axi_bvalid = st.wr_state == isr_pkg::ISR_RESP;
   assign s_axi_bresp = st.bresp;
   assign s_axi_rvalid = st.rd_state == isr_pkg::ISR_RESP;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign irq = |(st.irq_status & st.irq_mask);
   always_comb begin
      logic [7:0] wa;
      logic [31:0] wd;
      logic [31:0] m;
      logic [31:0] rv;
      logic ok;
      wa = st.aw_held ? st.aw_addr : s_axi_awaddr;
      wd = st.w_held ? st.w_data : s_axi_wdata;
      m = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      if (st.w_held) begin
         m = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
      end
      rv = 32'h0000_0000;
      ok = 1'b1;
      next_st = st;
      next_st.q1 = s0;
      next_st.q2 = st.q1;
      next_st.q3 = st.q2;
      next_st.qhold = held;
      next_st.o1 = o0;
      next_st.o2 = st.o1;
      next_st.o3 = st.o2;
      next_st.ohold = oheld;
      // Status bits: set wins over the read clear in the same cycle.
      if (rd_go && s_axi_araddr == `ISR_IRQ_STATUS) begin
         next_st.irq_status = 4'h0;
      end
      next_st.irq_status = next_st.irq_status | set_new;
      // Write channel.
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (wr_go) begin
         if (wa == `ISR_QUES_PTR) begin
            next_st.ques_ptr = (st.ques_ptr & ~m[15:0]) | (wd[15:0] & m[15:0]); // RQ5
         end else if (wa == `ISR_QUES_NTR) begin
            next_st.ques_ntr = (st.ques_ntr & ~m[15:0]) | (wd[15:0] & m[15:0]); // RQ5
         end else if (wa == `ISR_QUES_ENABLE) begin
            next_st.ques_en = (st.ques_en & ~m[15:0]) | (wd[15:0] & m[15:0]); // RQ7
         end else if (wa == `ISR_OPER_PTR) begin
            next_st.oper_ptr = (st.oper_ptr & ~m[15:0]) | (wd[15:0] & m[15:0]); // RQ5
         end else if (wa == `ISR_OPER_NTR) begin
            next_st.oper_ntr = (st.oper_ntr & ~m[15:0]) | (wd[15:0] & m[15:0]); // RQ5
         end else if (wa == `ISR_OPER_ENABLE) begin
            next_st.oper_en = (st.oper_en & ~m[15:0]) | (wd[15:0] & m[15:0]); // RQ7
         end else if (wa == `ISR_ESR_ENABLE) begin
            next_st.esr_en = (st.esr_en & ~m[7:0]) | (wd[7:0] & m[7:0]); // RQ7
         end else if (wa == `ISR_STB_ENABLE) begin
            next_st.stb_en = (st.stb_en & ~m[7:0]) | (wd[7:0] & m[7:0]); // RQ7
         end else if (wa == `ISR_IRQ_MASK) begin
            next_st.irq_mask = (st.irq_mask & ~m[3:0]) | (wd[3:0] & m[3:0]);
         end else if (wa[1:0] != 2'b00 || wa > `ISR_IRQ_MASK) begin
            ok = 1'b0;
         end
         next_st.bresp = ok ? `ISR_RESP_OKAY : `ISR_RESP_SLVERR;
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.wr_state = isr_pkg::ISR_RESP;
      end else if (st.wr_state == isr_pkg::ISR_RESP && s_axi_bready) begin
         next_st.wr_state = isr_pkg::ISR_IDLE;
      end
      // Read channel; condition reads have no side effect.
      ok = 1'b1;
      if (rd_go) begin
         if (s_axi_araddr == `ISR_QUES_COND) begin
            rv[15:0] = ques_cond; // RQ4
         end else if (s_axi_araddr == `ISR_QUES_PTR) begin
            rv[15:0] = st.ques_ptr;
         end else if (s_axi_araddr == `ISR_QUES_NTR) begin
            rv[15:0] = st.ques_ntr;
         end else if (s_axi_araddr == `ISR_QUES_EVENT) begin
            rv[15:0] = ques_ev; // RQ6
         end else if (s_axi_araddr == `ISR_QUES_ENABLE) begin
            rv[15:0] = st.ques_en;
         end else if (s_axi_araddr == `ISR_OPER_COND) begin
            rv[15:0] = oper_cond; // RQ4
         end else if (s_axi_araddr == `ISR_OPER_PTR) begin
            rv[15:0] = st.oper_ptr;
         end else if (s_axi_araddr == `ISR_OPER_NTR) begin
            rv[15:0] = st.oper_ntr;
         end else if (s_axi_araddr == `ISR_OPER_EVENT) begin
            rv[15:0] = oper_ev; // RQ6
         end else if (s_axi_araddr == `ISR_OPER_ENABLE) begin
            rv[15:0] = st.oper_en;
         end else if (s_axi_araddr == `ISR_ESR_EVENT) begin
            rv[7:0] = esr_ev; // RQ6
         end else if (s_axi_araddr == `ISR_ESR_ENABLE) begin
            rv[7:0] = st.esr_en;
         end else if (s_axi_araddr == `ISR_STB_EVENT) begin
            rv[7:0] = stb_ev; // RQ6
         end else if (s_axi_araddr == `ISR_STB_ENABLE) begin
            rv[7:0] = st.stb_en;
         end else if (s_axi_araddr == `ISR_IRQ_STATUS) begin
            rv[3:0] = st.irq_status;
         end else if (s_axi_araddr == `ISR_IRQ_MASK) begin
            rv[3:0] = st.irq_mask;
         end else begin
            ok = 1'b0;
         end
         next_st.rdata = rv;
         next_st.rresp = ok ? `ISR_RESP_OKAY : `ISR_RESP_SLVERR;
         next_st.rd_state = isr_pkg::ISR_RESP;
      end else if (st.rd_state == isr_pkg::ISR_RESP && s_axi_rready) begin
         next_st.rd_state = isr_pkg::ISR_IDLE;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.ques_ptr <= `ISR_PTR_RESET;
         st.oper_ptr <= `ISR_PTR_RESET;
         st.wr_state <= isr_pkg::ISR_IDLE;
         st.rd_state <= isr_pkg::ISR_IDLE;
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

//--- testbench/isr_status_sva.sv
// Concurrent checks on the bus ports of the status reporting block.
// Assumes one clock domain and the port names of the top module.
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"
module isr_status_sva (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Write side.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read side.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt.
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic ar_go = s_axi_arvalid && s_axi_arready;
   wire logic w_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   a_write_answer: assert property (w_go |=> s_axi_bvalid) else $error("no write answer");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_read_answer: assert property (ar_go |=> s_axi_rvalid) else $error("no read answer");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_wide_width: assert property (ar_go && s_axi_araddr <= `ISR_OPER_ENABLE |=> s_axi_rdata[31:16] == 16'h0000)
      else $error("wide read too wide");
   a_narrow_width: assert property (ar_go && s_axi_araddr >= `ISR_ESR_EVENT && s_axi_araddr <= `ISR_STB_ENABLE
      |=> s_axi_rdata[31:8] == 24'h000000) else $error("narrow read too wide");
   a_bad_read: assert property (ar_go && s_axi_araddr > `ISR_IRQ_MASK
      |=> s_axi_rresp == `ISR_RESP_SLVERR && s_axi_rdata == 32'h00000000) else $error("unmapped read");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   c_write: cover property (w_go ##1 s_axi_bvalid);
   c_bad: cover property (ar_go ##1 s_axi_rresp == `ISR_RESP_SLVERR);
   c_irq: cover property ($rose(irq));
endmodule
bind isr_status_top isr_status_sva u_isr_status_sva (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

//--- testbench/tb_isr_status_top.sv
// Self-checking bench of the status block against an integer model.
// Assumes the rtl folder is compiled first and on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"
module tb_isr_status_top;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   logic [15:0] ques_in, oper_in;
   logic [7:0] esr_in, stb_in, awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, sum;
   logic [1:0] bresp, rresp;
   int n_mismatch, n_tests, irqst;
   int ev[4], pv[4], cfg[9];
   isr_status_top u_isr_status_top (.aclk(aclk), .aresetn(aresetn), .ques_in(ques_in), .oper_in(oper_in),
      .esr_in(esr_in), .stb_in(stb_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ques_summary(sum[0]),
      .oper_summary(sum[1]), .esr_summary(sum[2]), .stb_summary(sum[3]), .irq(irq));
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic conclude;
      $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang;
      n_mismatch++;
      $display("CHECK FAILED at %0t: bus wait ran out", $time);
      conclude();
   endtask
   // Ready is sampled at the falling edge, where it already holds its value for the next rising edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ga, gw;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         @(negedge aclk);
         ga = awvalid && awready;
         gw = wvalid && wready;
         if (bvalid) begin
            cmp({30'h0, bresp}, {30'h0, er});
            @(posedge aclk);
            bready <= 1'b0;
            return;
         end
         @(posedge aclk);
         if (ga) awvalid <= 1'b0;
         if (gw) wvalid <= 1'b0;
      end
      hang();
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic g;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         @(negedge aclk);
         g = arvalid && arready;
         if (rvalid) begin
            cmp(rdata, exp);
            cmp({30'h0, rresp}, {30'h0, er});
            @(posedge aclk);
            rready <= 1'b0;
            return;
         end
         @(posedge aclk);
         if (g) arvalid <= 1'b0;
      end
      hang();
   endtask
   // The model latches an edge only where the filter of that direction is set; standard sets see rises.
   task automatic drive(input logic [31:0] r1, input logic [31:0] r2);
      int nw[4], c;
      nw = '{r1 & 32'hFFFF, r1 >> 16, r2 & 32'hFF, (r2 >> 8) & 32'hFF};
      for (int i = 0; i < 4; i++) begin
         if (i < 2) c = (~pv[i] & nw[i] & cfg[3 * i]) | (pv[i] & ~nw[i] & cfg[3 * i + 1]);
         else c = ~pv[i] & nw[i] & 32'hFF;
         ev[i] |= c;
         if (c != 0) irqst |= 1 << i;
         pv[i] = nw[i];
      end
      @(posedge aclk);
      ques_in <= r1[15:0];
      oper_in <= r1[31:16];
      esr_in <= r2[7:0];
      stb_in <= r2[15:8];
      repeat (8) @(posedge aclk);
   endtask
   task automatic verify;
      logic [7:0] ea[4] = '{`ISR_QUES_EVENT, `ISR_OPER_EVENT, `ISR_ESR_EVENT, `ISR_STB_EVENT};
      int en[4];
      en = '{cfg[2], cfg[5], cfg[6], cfg[7]};
      @(negedge aclk);
      for (int i = 0; i < 4; i++) cmp({31'h0, sum[i]}, {31'h0, (ev[i] & en[i]) != 0});
      cmp({31'h0, irq}, {31'h0, (irqst & cfg[8]) != 0});
      chk(`ISR_QUES_COND, pv[0], `ISR_RESP_OKAY);
      chk(`ISR_OPER_COND, pv[1], `ISR_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         chk(ea[i], ev[i], `ISR_RESP_OKAY);
         ev[i] = 0;
         chk(ea[i], 0, `ISR_RESP_OKAY);
      end
      chk(`ISR_IRQ_STATUS, irqst, `ISR_RESP_OKAY);
      irqst = 0;
   endtask
   initial begin
      logic [7:0] ca[9] = '{`ISR_QUES_PTR, `ISR_QUES_NTR, `ISR_QUES_ENABLE, `ISR_OPER_PTR, `ISR_OPER_NTR,
         `ISR_OPER_ENABLE, `ISR_ESR_ENABLE, `ISR_STB_ENABLE, `ISR_IRQ_MASK};
      int wm[9] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFF, 32'hFF, 32'hF};
      aresetn = 1'b0;
      {ques_in, oper_in, esr_in, stb_in, awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      {n_mismatch, n_tests, irqst} = '0;
      ev = '{default: 0};
      pv = '{default: 0};
      void'($urandom(32'h3159c2e3));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int j = 0; j < 9; j++) begin
         cfg[j] = (j % 3 == 0 && j < 6) ? `ISR_PTR_RESET : 0;
         chk(ca[j], cfg[j], `ISR_RESP_OKAY);
      end
      $display("test reset values done");
      wr(8'h40, 32'h1, `ISR_RESP_SLVERR);
      chk(8'h40, 0, `ISR_RESP_SLVERR);
      chk(8'h06, 0, `ISR_RESP_SLVERR);
      $display("test unmapped done");
      for (int t = 0; t < 8; t++) begin
         for (int j = 0; j < 9; j++) begin
            cfg[j] = $urandom & wm[j];
            wr(ca[j], cfg[j], `ISR_RESP_OKAY);
            chk(ca[j], cfg[j], `ISR_RESP_OKAY);
         end
         drive($urandom, $urandom);
         drive($urandom, $urandom);
         verify();
         $display("test random round %0d done", t);
      end
      conclude();
   end
endmodule
`default_nettype wire
